// File: verilog/rx_ctrl_pkg.sv
// package: register map, field layout and counts of the receiver control port
// assumes one 100 MHz system clock; host bus pins are synchronous to it
package rx_ctrl_pkg;

    // =========================================================================
    // register offsets
    localparam logic [3:0] TUNING_WORD_BYTE0_OFS      = 4'h0;
    localparam logic [3:0] TUNING_WORD_BYTE1_OFS      = 4'h1;
    localparam logic [3:0] TUNING_WORD_BYTE2_OFS      = 4'h2;
    localparam logic [3:0] TUNING_WORD_BYTE3_OFS      = 4'h3;
    localparam logic [3:0] SYNC_AND_ACCUM_CONTROL_OFS = 4'h4;
    localparam logic [3:0] DECIMATION_FACTOR_LOW_OFS  = 4'h8;
    localparam logic [3:0] DECIMATION_FACTOR_HIGH_OFS = 4'h9;
    localparam logic [3:0] SAMPLE_STATUS_OFS          = 4'ha;
    localparam logic [3:0] DIAG_CHECKSUM_OFS          = 4'hb;
    localparam logic [3:0] INPHASE_SAMPLE_LOW_OFS     = 4'hc;
    localparam logic [3:0] INPHASE_SAMPLE_HIGH_OFS    = 4'hd;
    localparam logic [3:0] QUADRATURE_SAMPLE_LOW_OFS  = 4'he;
    localparam logic [3:0] QUADRATURE_SAMPLE_HIGH_OFS = 4'hf;

    // =========================================================================
    // sync_and_accum_control fields
    localparam int SYNC_SRC_BIT    = 0;  // 0 external sync, 1 internal counter
    localparam int SYNC_ALIGN_BIT  = 1;  // 1 counter restarts on external sync
    localparam int SYNC_SHORT_BIT  = 2;  // 1 short test period
    localparam int LOAD_MODE_LSB   = 3;  // two bits
    localparam int CLR_ON_SYS_BIT  = 5;
    localparam int CLR_ON_ACC_BIT  = 6;
    localparam int LOAD_NOW_BIT    = 7;  // self clearing

    // sample_status fields
    localparam int READY_BIT       = 0;
    localparam int MISSED_BIT      = 1;

    // =========================================================================
    // widths and counts
    localparam int TUNE_W          = 28;
    localparam int PHASE_ADDR_W    = 13;
    localparam int TRIG_W          = 12;
    localparam int SAMPLE_W        = 12;
    localparam int OUT_W           = 16;
    localparam int MIX_W           = 24;
    localparam int SYNC_CNT_W      = 20;
    localparam logic [19:0] SYNC_SHORT_CYCLES = 20'h0_0100;
    localparam logic [15:0] DECIM_MIN         = 16'h0010;
    localparam logic [15:0] DECIM_MAX         = 16'h4000;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;

    typedef enum logic [1:0] {
        LOAD_ALWAYS  = 2'b00,
        LOAD_ON_BIT  = 2'b01,
        LOAD_ON_ACC  = 2'b10,
        LOAD_ON_SYS  = 2'b11
    } load_mode_t;

endpackage

// File: verilog/nco_sincos.sv
// sine and cosine generator addressed by the top phase bits
// assumes the phase address is registered upstream; one cycle of latency
`timescale 1ns/10ps
module nco_sincos
    import rx_ctrl_pkg::*;
(
    input  wire logic                                  ref_clk,
    input  wire logic                                  rstn,
    input  wire logic [rx_ctrl_pkg::PHASE_ADDR_W-1:0]  phase,
    output logic signed [rx_ctrl_pkg::TRIG_W-1:0]      sine,
    output logic signed [rx_ctrl_pkg::TRIG_W-1:0]      cosine
);
    import rx_ctrl_pkg::*;

    typedef struct packed {
        logic signed [TRIG_W-1:0] sine;
        logic signed [TRIG_W-1:0] cosine;
    } sc_state_t;

    sc_state_t state;
    sc_state_t next_state;

    // =========================================================================
    // quarter wave fold, then 1.5x - 0.5x^3; a cubic keeps area tiny
    // at the cost of roughly two percent of shape error
    function automatic logic signed [TRIG_W-1:0] wave(input logic [PHASE_ADDR_W-1:0] p);
        logic [10:0] x;
        logic [21:0] x2;
        logic [21:0] x3;
        logic [12:0] y;
        logic [10:0] mag;
        x   = p[11] ? ~p[10:0] : p[10:0];
        x2  = x * x;
        x3  = x2[21:11] * x;
        y   = (13'(x) * 13'd3 - 13'(x3[21:11])) >> 1;
        mag = (y > 13'h07ff) ? 11'h7ff : y[10:0];
        wave = p[12] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction

    always_comb begin
        next_state.sine   = wave(phase);
        next_state.cosine = wave(phase + 13'h0800);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sine   = state.sine;
    assign cosine = state.cosine;

endmodule // nco_sincos

// File: verilog/receiver_control_port_and_tuner.sv
// control port, sync generator, tuning oscillator and mixer of the receiver
// assumes host pins are synchronous to ref_clk; filter and formatter sit outside
`timescale 1ns/10ps
module receiver_control_port_and_tuner
    import rx_ctrl_pkg::*;
#(
    parameter logic [19:0] SYNC_LONG_CYCLES = 20'hf_ffff  // period minus one
)
(
    input  wire logic                                 ref_clk,
    input  wire logic                                 rstn,
    input  wire logic                                 cs_n,
    input  wire logic                                 rd_wr,
    input  wire logic [3:0]                           addr,
    input  wire logic [7:0]                           data_in,
    output logic      [7:0]                           data_out,
    output logic                                      data_oe,
    input  wire logic                                 sys_sync_n,
    input  wire logic                                 accum_sync_n,
    input  wire logic                                 real_format,
    input  wire logic [7:0]                           checksum,
    input  wire logic signed [rx_ctrl_pkg::SAMPLE_W-1:0] sample_in,
    input  wire logic                                 filt_valid,
    input  wire logic [rx_ctrl_pkg::OUT_W-1:0]        filt_i,
    input  wire logic [rx_ctrl_pkg::OUT_W-1:0]        filt_q,
    output logic signed [rx_ctrl_pkg::MIX_W-1:0]      mix_i,
    output logic signed [rx_ctrl_pkg::MIX_W-1:0]      mix_q,
    output logic                                      decim_strobe,
    output logic                                      sync_strobe,
    output logic                                      sample_irq
);
    import rx_ctrl_pkg::*;

    // =========================================================================
    // state
    typedef struct packed {
        logic                         cs_s1;
        logic                         cs_s2;
        logic                         cs_prev;
        logic                         sys_prev;
        logic                         acc_prev;
        logic [7:0]                   tw0;
        logic [7:0]                   tw1;
        logic [7:0]                   tw2;
        logic [7:0]                   tw3;
        logic [7:0]                   ctrl;
        logic [7:0]                   dec_lo;
        logic [7:0]                   dec_hi;
        logic                         ready;
        logic                         missed;
        logic                         odd_phase;
        logic [OUT_W-1:0]             i_smp;
        logic [OUT_W-1:0]             q_smp;
        logic [TUNE_W-1:0]            tuning_word;
        logic [TUNE_W-1:0]            accum;
        logic [SYNC_CNT_W-1:0]        sync_cnt;
        logic [15:0]                  dec_cnt;
        logic [7:0]                   data_out;
        logic                         data_oe;
        logic signed [MIX_W-1:0]      mix_i;
        logic signed [MIX_W-1:0]      mix_q;
        logic                         decim_strobe;
        logic                         sync_strobe;
        logic                         sample_irq;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    logic signed [TRIG_W-1:0] sine;
    logic signed [TRIG_W-1:0] cosine;

    // =========================================================================
    // helpers
    function automatic logic [15:0] decim_limit(input logic [15:0] d);
        if (d < DECIM_MIN) begin
            decim_limit = DECIM_MIN;
        end else if (d > DECIM_MAX) begin
            decim_limit = DECIM_MAX;
        end else begin
            decim_limit = d;
        end
    endfunction

    function automatic logic [7:0] reg_read(input port_state_t s, input logic [3:0] a,
                                            input logic [7:0] sum);
        case (a)
            TUNING_WORD_BYTE0_OFS:      reg_read = s.tw0;
            TUNING_WORD_BYTE1_OFS:      reg_read = s.tw1;
            TUNING_WORD_BYTE2_OFS:      reg_read = s.tw2;
            TUNING_WORD_BYTE3_OFS:      reg_read = s.tw3;
            SYNC_AND_ACCUM_CONTROL_OFS: reg_read = s.ctrl;
            DECIMATION_FACTOR_LOW_OFS:  reg_read = s.dec_lo;
            DECIMATION_FACTOR_HIGH_OFS: reg_read = s.dec_hi;
            SAMPLE_STATUS_OFS:          reg_read = {6'h00, s.missed, s.ready};
            DIAG_CHECKSUM_OFS:          reg_read = sum;
            INPHASE_SAMPLE_LOW_OFS:     reg_read = s.i_smp[7:0];
            INPHASE_SAMPLE_HIGH_OFS:    reg_read = s.i_smp[15:8];
            QUADRATURE_SAMPLE_LOW_OFS:  reg_read = s.q_smp[7:0];
            QUADRATURE_SAMPLE_HIGH_OFS: reg_read = s.q_smp[15:8];
            default:                    reg_read = 8'h00;
        endcase
    endfunction

    // =========================================================================
    // oscillator trig lookup
    nco_sincos u_sincos (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .phase   (state.accum[TUNE_W-1 -: PHASE_ADDR_W]),
        .sine    (sine),
        .cosine  (cosine)
    );

    // =========================================================================
    // next state
    always_comb begin
        logic             cs_fall;
        logic             wr_evt;
        logic             rd_last;
        logic             sys_evt;
        logic             acc_evt;
        logic             sync_evt;
        logic             term;
        logic             load;
        logic             clr;
        logic             new_smp;
        logic [19:0]      period;
        logic [15:0]      dec_lim;
        logic [TUNE_W-1:0] tune_word;
        load_mode_t       mode;

        next_state = state;
        cs_fall    = 1'b0;
        wr_evt     = 1'b0;
        rd_last    = 1'b0;
        sys_evt    = 1'b0;
        acc_evt    = 1'b0;
        sync_evt   = 1'b0;
        term       = 1'b0;
        load       = 1'b0;
        clr        = 1'b0;
        new_smp    = 1'b0;
        period     = 20'h0_0000;
        dec_lim    = 16'h0000;
        tune_word  = '0;
        mode       = LOAD_ALWAYS;

        // strobe passes two flops before the write and read-clear logic acts on it; the read drive takes the raw pin
        next_state.cs_s1   = cs_n;
        next_state.cs_s2   = state.cs_s1;
        next_state.cs_prev = state.cs_s2;
        cs_fall = state.cs_prev & ~state.cs_s2;
        wr_evt  = cs_fall & ~rd_wr;
        rd_last = cs_fall & rd_wr & (addr == QUADRATURE_SAMPLE_HIGH_OFS);

        // pins are sampled on the rising clock edge
        next_state.sys_prev = sys_sync_n;
        next_state.acc_prev = accum_sync_n;
        sys_evt = state.sys_prev & ~sys_sync_n;
        acc_evt = state.acc_prev & ~accum_sync_n;

        // load strobe is single shot
        next_state.ctrl[LOAD_NOW_BIT] = 1'b0;

        if (wr_evt) begin
            case (addr)
                TUNING_WORD_BYTE0_OFS:      next_state.tw0    = data_in;
                TUNING_WORD_BYTE1_OFS:      next_state.tw1    = data_in;
                TUNING_WORD_BYTE2_OFS:      next_state.tw2    = data_in;
                TUNING_WORD_BYTE3_OFS:      next_state.tw3    = data_in;
                SYNC_AND_ACCUM_CONTROL_OFS: next_state.ctrl   = data_in;
                DECIMATION_FACTOR_LOW_OFS:  next_state.dec_lo = data_in;
                DECIMATION_FACTOR_HIGH_OFS: next_state.dec_hi = data_in;
                default:                    next_state.ctrl[LOAD_NOW_BIT] = 1'b0;
            endcase
        end

        // sync generator
        period = state.ctrl[SYNC_SHORT_BIT] ? SYNC_SHORT_CYCLES - 20'h0_0001
                                            : SYNC_LONG_CYCLES;
        // a shortened period must not wait for the counter to wrap
        term = (state.sync_cnt >= period);
        if (term | (state.ctrl[SYNC_ALIGN_BIT] & sys_evt)) begin
            next_state.sync_cnt = '0;
        end else begin
            next_state.sync_cnt = state.sync_cnt + 20'h0_0001;
        end
        // the host keeps internal resync to power-of-two factors
        sync_evt = state.ctrl[SYNC_SRC_BIT] ? term : sys_evt;
        next_state.sync_strobe = sync_evt;

        // frequency register
        tune_word = {state.tw3[3:0], state.tw2, state.tw1, state.tw0};
        mode = load_mode_t'(state.ctrl[LOAD_MODE_LSB +: 2]);
        case (mode)
            LOAD_ALWAYS: load = 1'b1;
            LOAD_ON_BIT: load = state.ctrl[LOAD_NOW_BIT];
            LOAD_ON_ACC: load = acc_evt;
            LOAD_ON_SYS: load = sync_evt;
            default:     load = 1'b0;
        endcase
        if (load) begin
            next_state.tuning_word = tune_word;
        end

        // accumulator free runs unless a selected sync clears it
        clr = (state.ctrl[CLR_ON_SYS_BIT] & sync_evt)
            | (state.ctrl[CLR_ON_ACC_BIT] & acc_evt);
        next_state.accum = clr ? '0 : state.accum + state.tuning_word;

        // mixer
        next_state.mix_i = MIX_W'(sample_in * cosine);
        next_state.mix_q = MIX_W'(-(sample_in * sine));

        // decimation timing; sync restarts the count so the filter lines up
        dec_lim = decim_limit({state.dec_hi, state.dec_lo});
        if (sync_evt | (state.dec_cnt >= dec_lim - 16'h0001)) begin
            next_state.dec_cnt = 16'h0000;
        end else begin
            next_state.dec_cnt = state.dec_cnt + 16'h0001;
        end
        next_state.decim_strobe = ~sync_evt & (state.dec_cnt >= dec_lim - 16'h0001);

        // sample capture
        new_smp = 1'b0;
        if (sync_evt) begin
            next_state.odd_phase = 1'b0;
        end
        if (filt_valid) begin
            if (real_format) begin
                if (state.odd_phase) begin
                    next_state.q_smp = filt_i;
                    new_smp = 1'b1;
                end else begin
                    next_state.i_smp = filt_i;
                end
                next_state.odd_phase = ~state.odd_phase;
            end else begin
                next_state.i_smp = filt_i;
                next_state.q_smp = filt_q;
                new_smp = 1'b1;
            end
        end

        // status flags: a new sample beats a clear in the same cycle
        if (rd_last | (wr_evt & (addr == SAMPLE_STATUS_OFS) & data_in[READY_BIT])) begin
            next_state.ready = 1'b0;
        end
        if (wr_evt & (addr == SAMPLE_STATUS_OFS) & data_in[MISSED_BIT]) begin
            next_state.missed = 1'b0;
        end
        if (new_smp) begin
            next_state.ready = 1'b1;
            if (state.ready & ~rd_last) begin
                next_state.missed = 1'b1;
            end
        end
        next_state.sample_irq = next_state.ready;

        // read drive; lags the pins by one clock each way
        next_state.data_oe  = ~cs_n & rd_wr;
        next_state.data_out = (~cs_n & rd_wr) ? reg_read(state, addr, checksum) : 8'h00;
    end

    // =========================================================================
    // registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state          <= '0;
            state.cs_s1    <= 1'b1;
            state.cs_s2    <= 1'b1;
            state.cs_prev  <= 1'b1;
            state.sys_prev <= 1'b1;
            state.acc_prev <= 1'b1;
            state.ctrl     <= CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign data_out     = state.data_out;
    assign data_oe      = state.data_oe;
    assign mix_i        = state.mix_i;
    assign mix_q        = state.mix_q;
    assign decim_strobe = state.decim_strobe;
    assign sync_strobe  = state.sync_strobe;
    assign sample_irq   = state.sample_irq;

endmodule // receiver_control_port_and_tuner

// File: test/rx_ctrl_properties.sv
// checker: port-level relations of the receiver control port and tuner
// assumes it is bound into receiver_control_port_and_tuner
`timescale 1ns/10ps
module rx_ctrl_properties
    import rx_ctrl_pkg::*;
#(
    parameter logic [19:0] SYNC_LONG_CYCLES = 20'hf_ffff
)
(
    input wire logic                                    ref_clk,
    input wire logic                                    rstn,
    input wire logic                                    cs_n,
    input wire logic                                    rd_wr,
    input wire logic [3:0]                              addr,
    input wire logic [7:0]                              data_in,
    input wire logic [7:0]                              data_out,
    input wire logic                                    data_oe,
    input wire logic                                    sys_sync_n,
    input wire logic                                    accum_sync_n,
    input wire logic                                    real_format,
    input wire logic [7:0]                              checksum,
    input wire logic signed [rx_ctrl_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic                                    filt_valid,
    input wire logic [rx_ctrl_pkg::OUT_W-1:0]           filt_i,
    input wire logic [rx_ctrl_pkg::OUT_W-1:0]           filt_q,
    input wire logic signed [rx_ctrl_pkg::MIX_W-1:0]    mix_i,
    input wire logic signed [rx_ctrl_pkg::MIX_W-1:0]    mix_q,
    input wire logic                                    decim_strobe,
    input wire logic                                    sync_strobe,
    input wire logic                                    sample_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================================
    // host bus
    oe_on_read_a: assert property (!cs_n && rd_wr |=> data_oe)
        else $error("data pins idle during a read");
    oe_only_read_a: assert property (data_oe |-> $past(!cs_n && rd_wr))
        else $error("data pins driven outside a read");
    idle_zero_a: assert property (!data_oe |-> data_out == 8'h00)
        else $error("read data not cleared while idle");
    checksum_read_a: assert property (!cs_n && rd_wr && addr == 4'hb
        |=> data_out == $past(checksum))
        else $error("checksum read mismatch");
    unmapped_zero_a: assert property (!cs_n && rd_wr && addr inside {[4'h5:4'h7]}
        |=> data_out == 8'h00)
        else $error("unmapped read not zero");
    // ==========================================================================
    // samples, strobes, mixer
    // quiet bus now, one and four edges back, so a read-clear of the ready flag cannot race
    sample_irq_a: assert property (filt_valid && !real_format && cs_n && $past(cs_n)
        && $past(cs_n, 4) |-> ##2 sample_irq)
        else $error("no interrupt after a new sample");
    decim_pulse_a: assert property (decim_strobe |=> !decim_strobe [*8])
        else $error("decimation strobe too close");
    sync_pulse_a: assert property (sync_strobe |=> !sync_strobe [*8])
        else $error("sync strobe too close");
    mix_zero_a: assert property ((sample_in == 12'h000) [*3]
        |=> mix_i == 24'h00_0000 && mix_q == 24'h00_0000)
        else $error("mixer output not zero for zero input");
    cover property (!cs_n && !rd_wr);
    cover property (filt_valid ##2 sample_irq);
    cover property ($fell(accum_sync_n));
endmodule // rx_ctrl_properties

bind receiver_control_port_and_tuner rx_ctrl_properties #(
    .SYNC_LONG_CYCLES(SYNC_LONG_CYCLES)
) chk_i (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .rd_wr(rd_wr), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sys_sync_n(sys_sync_n),
    .accum_sync_n(accum_sync_n), .real_format(real_format), .checksum(checksum),
    .sample_in(sample_in), .filt_valid(filt_valid), .filt_i(filt_i), .filt_q(filt_q),
    .mix_i(mix_i), .mix_q(mix_q), .decim_strobe(decim_strobe),
    .sync_strobe(sync_strobe), .sample_irq(sample_irq));

// File: test/host_model.sv
// host model: byte-wide strobe bus master of the control port
// assumes data_in is the inbound half of the shared data pins
`timescale 1ns/10ps
module host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            rd_wr,
    output logic [3:0]      addr,
    output logic [7:0]      data_in
);
    logic [7:0] drv = 8'h00;
    // the device wins the pins while it drives them
    assign data_in = data_oe ? data_out : drv;
    initial begin
        cs_n = 1'b1;
        rd_wr = 1'b1;
        addr = 4'h0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        rd_wr = 1'b0;
        drv = d;
        cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        drv = ~d; // released pins must not keep the last byte
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        rd_wr = 1'b1;
        cs_n = 1'b0;
        // sample between edges, where the registered read data has settled
        repeat (2) @(negedge ref_clk);
        d = data_out;
        @(negedge ref_clk);
        cs_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
endmodule // host_model

// File: test/receiver_control_port_and_tuner_tb_top.sv
// testbench: drives the control port through the host model and checks ports
// assumes the package, the checker with its bind and the host model come first
`timescale 1ns/10ps
module receiver_control_port_and_tuner_tb_top;
    import rx_ctrl_pkg::*;
    localparam logic [19:0] SLC = 20'h0_03ff;
    logic ref_clk = 1'b0, rstn = 1'b0, cs_n, rd_wr, data_oe, filt_valid = 1'b0;
    logic sys_sync_n = 1'b1, accum_sync_n = 1'b1, real_format = 1'b0;
    logic decim_strobe, sync_strobe, sample_irq;
    logic [3:0] addr;
    logic [7:0] data_in, data_out, checksum = 8'h5a;
    logic [15:0] filt_i = 16'h0000, filt_q = 16'h0000;
    logic signed [11:0] sample_in = 12'sh000;
    logic signed [23:0] mix_i, mix_q;
    int fail_count = 0, tests_run = 0, n;
    always #5 ref_clk = ~ref_clk;
    receiver_control_port_and_tuner #(.SYNC_LONG_CYCLES(SLC)) uut (.ref_clk(ref_clk),
        .rstn(rstn), .cs_n(cs_n), .rd_wr(rd_wr), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .sys_sync_n(sys_sync_n),
        .accum_sync_n(accum_sync_n), .real_format(real_format), .checksum(checksum),
        .sample_in(sample_in), .filt_valid(filt_valid), .filt_i(filt_i), .filt_q(filt_q),
        .mix_i(mix_i), .mix_q(mix_q), .decim_strobe(decim_strobe),
        .sync_strobe(sync_strobe), .sample_irq(sample_irq));
    host_model host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
        .cs_n(cs_n), .rd_wr(rd_wr), .addr(addr), .data_in(data_in));
    // ==========================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk(32'(v), 32'(e));
    endtask
    task automatic smp(input logic [15:0] i, input logic [15:0] q);
        @(negedge ref_clk);
        filt_i = i;
        filt_q = q;
        filt_valid = 1'b1;
        @(negedge ref_clk);
        filt_valid = 1'b0;
    endtask
    task automatic pulse(input bit acc);
        @(negedge ref_clk);
        if (acc) accum_sync_n = 1'b0; else sys_sync_n = 1'b0;
        @(negedge ref_clk);
        accum_sync_n = 1'b1;
        sys_sync_n = 1'b1;
    endtask
    // last of several gaps measured: the first may straddle a setting change
    task automatic gap(input bit w, input int rounds, output int g);
        for (int r = 0; r < rounds; r++) begin
            g = 0;
            do begin
                @(negedge ref_clk);
                g++;
            end while ((w ? sync_strobe : decim_strobe) !== 1'b1 && g < 20000);
            if (g >= 20000) begin
                chk(0, 1);
                report_and_stop();
            end
        end
    endtask
    // settle the pipeline, then look for any quadrature activity
    task automatic osc(input bit e);
        bit m;
        m = 1'b0;
        repeat (8) @(negedge ref_clk);
        repeat (16) begin
            @(negedge ref_clk);
            if (mix_q !== 24'sh00_0000) m = 1'b1;
        end
        chk(32'(m), 32'(e));
        // zero phase: full-scale cosine times the input on the in-phase path
        if (!e) chk(32'(mix_i), 32'h0007_ff00);
    endtask
    // ==========================================================================
    // scenarios
    task automatic t_reset;
        logic [3:0] al [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'h5};
        foreach (al[k]) rchk(al[k], CTRL_RESET);
    endtask
    task automatic t_osc;
        sample_in = 12'sh100;
        host.wr(4'h4, 8'h08);
        host.wr(4'h3, 8'h04);
        osc(1'b0);
        host.wr(4'h4, 8'h88);
        osc(1'b1);
        host.wr(4'h4, 8'h50);
        host.wr(4'h3, 8'h00);
        osc(1'b1);
        pulse(1'b1);
        osc(1'b0);
        host.wr(4'h4, 8'h00);
        host.wr(4'h3, 8'h04);
        osc(1'b1);
        host.wr(4'h4, 8'h38);
        host.wr(4'h3, 8'h00);
        osc(1'b1);
        pulse(1'b0);
        osc(1'b0);
        sample_in = 12'sh000;
    endtask
    task automatic t_regs;
        logic [3:0] al [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        foreach (al[k]) host.wr(al[k], {4'h1, al[k]});
        foreach (al[k]) rchk(al[k], {4'h1, al[k]});
        host.wr(4'hb, 8'h00);
        rchk(4'hb, 8'h5a);
        host.wr(4'h5, 8'hff);
        rchk(4'h5, 8'h00);
    endtask
    task automatic t_complex;
        smp(16'h1234, 16'hbeef);
        repeat (2) @(negedge ref_clk);
        chk(32'(sample_irq), 1);
        rchk(4'ha, 8'h01);
        rchk(4'hc, 8'h34);
        rchk(4'hd, 8'h12);
        rchk(4'he, 8'hef);
        rchk(4'hf, 8'hbe);
        rchk(4'ha, 8'h00);
        chk(32'(sample_irq), 0);
        smp(16'h0001, 16'h0002);
        smp(16'h0003, 16'h0004);
        rchk(4'ha, 8'h03);
        host.wr(4'ha, 8'h03);
        rchk(4'ha, 8'h00);
    endtask
    task automatic t_real;
        real_format = 1'b1;
        pulse(1'b0);
        smp(16'h1111, 16'h0000);
        smp(16'h2222, 16'h0000);
        rchk(4'hc, 8'h11);
        rchk(4'he, 8'h22);
        rchk(4'hf, 8'h22);
        real_format = 1'b0;
    endtask
    // runs after t_decim, so the decimation factor is a power of two
    task automatic t_sync;
        host.wr(4'h4, 8'h05);
        gap(1'b1, 3, n);
        chk(n, 256);
        host.wr(4'h4, 8'h07);
        gap(1'b1, 1, n);
        pulse(1'b0);
        gap(1'b1, 1, n);
        chk(n, 256);
        host.wr(4'h4, 8'h01);
        gap(1'b1, 3, n);
        chk(n, int'(SLC) + 1);
        host.wr(4'h4, 8'h00);
    endtask
    task automatic t_decim;
        host.wr(4'h9, 8'h00);
        host.wr(4'h8, 8'h0f);
        gap(1'b0, 3, n);
        chk(n, 16);
        host.wr(4'h8, 8'h20);
        gap(1'b0, 3, n);
        chk(n, 32);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_osc();
        t_regs();
        t_complex();
        t_real();
        t_decim();
        t_sync();
        report_and_stop();
    end
endmodule // receiver_control_port_and_tuner_tb_top
